// ### logic/sgt_pkg.sv
// Constants, register map and mode types of the smart card guard timer unit.
// Assumes one 125 MHz clock and an 8-bit register port with registered read data.
package sgt_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_DC_LOW  = 8'h16;
  localparam logic [7:0] ADDR_DC_HIGH = 8'h17;
  localparam logic [7:0] ADDR_CW_LOW  = 8'h18;
  localparam logic [7:0] ADDR_CW_HIGH = 8'h19;
  localparam logic [7:0] ADDR_SP_HIGH = 8'h1A;
  localparam logic [7:0] ADDR_SP_LOW  = 8'h1B;
  localparam logic [7:0] ADDR_GR_A    = 8'h1C;
  localparam logic [7:0] ADDR_GR_B    = 8'h1D;
  localparam logic [7:0] ADDR_PRM     = 8'h1E;
  localparam logic [7:0] ADDR_TCTL    = 8'h1F;
  localparam logic [7:0] ADDR_ICTL    = 8'h20;
  localparam logic [7:0] ADDR_IRQ_STS = 8'h21;
  localparam logic [7:0] ADDR_IRQ_MSK = 8'h22;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int          PRM_RESET_MODE_BIT  = 0;
  localparam int          PRM_SELECT_BIT      = 1;
  localparam int          TCTL_CLEAR_BIT      = 7;
  localparam int          ICTL_ENABLE_BIT     = 0;
  localparam int          IRQ_TS_WAIT_BIT     = 0;
  localparam int          IRQ_DC_ZERO_BIT     = 1;
  localparam int          IRQ_SPACING_BIT     = 2;
  localparam int          IRQ_BITS            = 3;
  localparam logic [7:0]  DC_RESET            = 8'hFF;
  localparam logic [7:0]  BYTE_RESET          = 8'h00;
  localparam logic [2:0]  IRQ_RESET           = 3'h0;

  typedef enum logic [1:0] {SGT_T0, SGT_T1, SGT_ATR} sgt_mode_t;

endpackage

// ### logic/sgt_timers.sv
// Guard timer, down counter and character timing registers of a smart card port.
// Assumes etu_tick, rx_start_bit and rx_char_done are one-cycle pulses made on clk
// by the clock divider and receiver next to this block.
`timescale 1ns/100ps
module sgt_timers (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Receiver and transmitter side
  input  wire logic        etu_tick,
  input  wire logic        rx_start_bit,
  input  wire logic        rx_char_done,
  output logic             tx_allow,
  output logic             rx_fifo_block,
  output logic      [7:0]  extra_guard,
  output logic      [15:0] char_wait_reload,
  // Card and interrupt
  output logic             card_reset_line,
  output logic             irq
);

  // ----------------------------------------------------------------------
  // Mode decoding
  // ----------------------------------------------------------------------
  function automatic sgt_pkg::sgt_mode_t decode_mode(input logic [1:0] prm);
    if (prm[sgt_pkg::PRM_SELECT_BIT]) begin
      decode_mode = sgt_pkg::SGT_T1;
    end else if (prm[sgt_pkg::PRM_RESET_MODE_BIT]) begin
      decode_mode = sgt_pkg::SGT_ATR;
    end else begin
      decode_mode = sgt_pkg::SGT_T0;
    end
  endfunction

  function automatic logic wr_at(input logic [7:0] a);
    wr_at = reg_wr && (reg_addr == a);
  endfunction

  typedef enum logic [2:0] {SGT_IDLE, SGT_RST_PULSE, SGT_WAIT_TS, SGT_ATR_DONE,
                            SGT_PROTO} sgt_state_t;

  logic [15:0]                dc_r;
  logic [15:0]                cw_r;
  logic [15:0]                sp_r;
  logic [7:0]                 gra_r;
  logic [7:0]                 grb_r;
  logic [7:0]                 lat_a_r;
  logic [7:0]                 lat_b_r;
  logic [1:0]                 prm_r;
  logic                       en_r;
  logic [sgt_pkg::IRQ_BITS-1:0] sts_r;
  logic [sgt_pkg::IRQ_BITS-1:0] sts_nxt;
  logic [sgt_pkg::IRQ_BITS-1:0] msk_r;
  logic [sgt_pkg::IRQ_BITS-1:0] msk_nxt;
  logic [sgt_pkg::IRQ_BITS-1:0] ev;
  logic [sgt_pkg::IRQ_BITS-1:0] clr;
  sgt_state_t                 st_r;
  sgt_state_t                 st_nxt;
  logic [7:0]                 g_cnt_r;
  logic [7:0]                 g_cnt_nxt;
  logic                       crst_nxt;
  logic [15:0]                sp_cnt_r;
  logic                       sp_arm_r;
  logic                       prm_wr;
  logic                       gclr;
  logic                       ts_expire;
  logic                       dc_zero_ev;
  logic                       sp_ev;

  assign prm_wr = wr_at(sgt_pkg::ADDR_PRM);
  assign gclr   = wr_at(sgt_pkg::ADDR_TCTL) && reg_wdata[sgt_pkg::TCTL_CLEAR_BIT];

  // ----------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cw_r  <= {sgt_pkg::BYTE_RESET, sgt_pkg::BYTE_RESET};
      sp_r  <= {sgt_pkg::BYTE_RESET, sgt_pkg::BYTE_RESET};
      gra_r <= sgt_pkg::BYTE_RESET;
      grb_r <= sgt_pkg::BYTE_RESET;
      prm_r <= 2'h0;
      msk_r <= sgt_pkg::IRQ_RESET;
    end else begin
      if (wr_at(sgt_pkg::ADDR_CW_LOW)) begin
        cw_r[7:0] <= reg_wdata;
      end
      if (wr_at(sgt_pkg::ADDR_CW_HIGH)) begin
        cw_r[15:8] <= reg_wdata;
      end
      if (wr_at(sgt_pkg::ADDR_SP_LOW)) begin
        sp_r[7:0] <= reg_wdata;
      end
      if (wr_at(sgt_pkg::ADDR_SP_HIGH)) begin
        sp_r[15:8] <= reg_wdata;
      end
      if (wr_at(sgt_pkg::ADDR_GR_A)) begin
        gra_r <= reg_wdata;
      end
      if (wr_at(sgt_pkg::ADDR_GR_B)) begin
        grb_r <= reg_wdata;
      end
      if (prm_wr) begin
        prm_r <= reg_wdata[1:0];
      end
      if (wr_at(sgt_pkg::ADDR_IRQ_MSK)) begin
        msk_r <= reg_wdata[sgt_pkg::IRQ_BITS-1:0];
      end
    end
  end

  // Reloads reach the timer only through these copies, so a half-written
  // pair of reloads never steers a running sequence.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      lat_a_r <= sgt_pkg::BYTE_RESET;
      lat_b_r <= sgt_pkg::BYTE_RESET;
    end else if (prm_wr) begin
      lat_a_r <= gra_r;
      lat_b_r <= grb_r;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      en_r <= 1'b0;
    end else if (gclr) begin
      en_r <= 1'b0;
    end else if (wr_at(sgt_pkg::ADDR_ICTL)) begin
      en_r <= reg_wdata[sgt_pkg::ICTL_ENABLE_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // General purpose down counter
  // ----------------------------------------------------------------------
  assign dc_zero_ev = etu_tick && (dc_r == 16'h0001) &&
                      !wr_at(sgt_pkg::ADDR_DC_LOW) && !wr_at(sgt_pkg::ADDR_DC_HIGH);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      dc_r <= {sgt_pkg::DC_RESET, sgt_pkg::DC_RESET};
    end else if (wr_at(sgt_pkg::ADDR_DC_LOW)) begin
      dc_r[7:0] <= reg_wdata;
    end else if (wr_at(sgt_pkg::ADDR_DC_HIGH)) begin
      dc_r[15:8] <= reg_wdata;
    end else if (etu_tick && dc_r != 16'h0000) begin
      dc_r <= dc_r - 16'h0001;
    end
  end

  // ----------------------------------------------------------------------
  // Character spacing watch
  // ----------------------------------------------------------------------
  // The count restarts on every start bit edge, so the spacing is measured
  // leading edge to leading edge; a zero setting turns the watch off.
  assign sp_ev = sp_arm_r && etu_tick && !rx_start_bit && (sp_r != 16'h0000) &&
                 (sp_cnt_r == sp_r);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      sp_cnt_r <= 16'h0000;
      sp_arm_r <= 1'b0;
    end else if (rx_start_bit) begin
      sp_cnt_r <= 16'h0000;
      sp_arm_r <= 1'b1;
    end else if (sp_ev) begin
      sp_arm_r <= 1'b0;
    end else if (etu_tick && sp_arm_r) begin
      sp_cnt_r <= sp_cnt_r + 16'h0001;
    end
  end

  // ----------------------------------------------------------------------
  // Guard timer sequencer
  // ----------------------------------------------------------------------
  assign ts_expire = (st_r == SGT_WAIT_TS) && en_r && !prm_wr && !rx_start_bit &&
                     etu_tick && (g_cnt_r <= 8'h01);

  always_comb begin
    st_nxt    = st_r;
    g_cnt_nxt = g_cnt_r;
    crst_nxt  = card_reset_line;
    if (!en_r || prm_wr) begin
      st_nxt = SGT_IDLE;
    end else begin
      case (st_r)
        SGT_IDLE: begin
          if (decode_mode(prm_r) == sgt_pkg::SGT_ATR) begin
            crst_nxt  = 1'b0;
            g_cnt_nxt = lat_b_r;
            st_nxt    = SGT_RST_PULSE;
          end else begin
            g_cnt_nxt = 8'h00;
            st_nxt    = SGT_PROTO;
          end
        end
        SGT_RST_PULSE: begin
          if (g_cnt_r == 8'h00 || (etu_tick && g_cnt_r == 8'h01)) begin
            crst_nxt  = 1'b1;
            g_cnt_nxt = lat_a_r;
            st_nxt    = SGT_WAIT_TS;
          end else if (etu_tick) begin
            g_cnt_nxt = g_cnt_r - 8'h01;
          end
        end
        SGT_WAIT_TS: begin
          if (rx_start_bit || ts_expire) begin
            st_nxt = SGT_ATR_DONE;
          end else if (etu_tick) begin
            g_cnt_nxt = g_cnt_r - 8'h01;
          end
        end
        SGT_ATR_DONE: begin
          st_nxt = SGT_ATR_DONE;
        end
        SGT_PROTO: begin
          if (rx_char_done) begin
            g_cnt_nxt = lat_b_r;
          end else if (etu_tick && g_cnt_r != 8'h00) begin
            g_cnt_nxt = g_cnt_r - 8'h01;
          end
        end
        default: begin
          st_nxt = SGT_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_r            <= SGT_IDLE;
      g_cnt_r         <= 8'h00;
      card_reset_line <= 1'b0;
    end else begin
      st_r            <= st_nxt;
      g_cnt_r         <= g_cnt_nxt;
      card_reset_line <= crst_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs to the transmitter and receiver
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tx_allow <= 1'b1;
    end else begin
      tx_allow <= !(en_r && st_r == SGT_PROTO &&
                    (rx_char_done || g_cnt_r != 8'h00));
    end
  end

  // The block stays until software rewrites the mode, which is also how a
  // fresh reset sequence is started.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rx_fifo_block <= 1'b0;
    end else if (ts_expire) begin
      rx_fifo_block <= 1'b1;
    end else if (prm_wr) begin
      rx_fifo_block <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      extra_guard      <= sgt_pkg::BYTE_RESET;
      char_wait_reload <= {sgt_pkg::BYTE_RESET, sgt_pkg::BYTE_RESET};
    end else begin
      extra_guard      <= (decode_mode(prm_r) == sgt_pkg::SGT_ATR) ? 8'h00 : lat_a_r;
      char_wait_reload <= cw_r;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------------
  assign ev[sgt_pkg::IRQ_TS_WAIT_BIT] = ts_expire;
  assign ev[sgt_pkg::IRQ_DC_ZERO_BIT] = dc_zero_ev;
  assign ev[sgt_pkg::IRQ_SPACING_BIT] = sp_ev;

  always_comb begin
    clr = wr_at(sgt_pkg::ADDR_IRQ_STS) ? reg_wdata[sgt_pkg::IRQ_BITS-1:0]
                                        : {sgt_pkg::IRQ_BITS{1'b0}};
    clr[sgt_pkg::IRQ_TS_WAIT_BIT] = clr[sgt_pkg::IRQ_TS_WAIT_BIT] | gclr;
  end

  // A new event wins over a clear in the same cycle.
  assign sts_nxt = (sts_r & ~clr) | ev;
  // The level follows a mask write in the same cycle as the status it gates.
  assign msk_nxt = wr_at(sgt_pkg::ADDR_IRQ_MSK) ? reg_wdata[sgt_pkg::IRQ_BITS-1:0] : msk_r;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      sts_r <= sgt_pkg::IRQ_RESET;
      irq   <= 1'b0;
    end else begin
      sts_r <= sts_nxt;
      irq   <= |(sts_nxt & msk_nxt);
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (!reg_rd) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        sgt_pkg::ADDR_DC_LOW:  reg_rdata <= dc_r[7:0];
        sgt_pkg::ADDR_DC_HIGH: reg_rdata <= dc_r[15:8];
        sgt_pkg::ADDR_CW_LOW:  reg_rdata <= cw_r[7:0];
        sgt_pkg::ADDR_CW_HIGH: reg_rdata <= cw_r[15:8];
        sgt_pkg::ADDR_SP_HIGH: reg_rdata <= sp_r[15:8];
        sgt_pkg::ADDR_SP_LOW:  reg_rdata <= sp_r[7:0];
        sgt_pkg::ADDR_GR_A:    reg_rdata <= gra_r;
        sgt_pkg::ADDR_GR_B:    reg_rdata <= grb_r;
        sgt_pkg::ADDR_PRM:     reg_rdata <= {6'h00, prm_r};
        sgt_pkg::ADDR_TCTL:    reg_rdata <= 8'h00;
        sgt_pkg::ADDR_ICTL:    reg_rdata <= {7'h00, en_r};
        sgt_pkg::ADDR_IRQ_STS: reg_rdata <= {5'h00, sts_r};
        sgt_pkg::ADDR_IRQ_MSK: reg_rdata <= {5'h00, msk_r};
        default:               reg_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_dc_low_write: assert property (@(posedge clk) disable iff (!resetn)
    wr_at(sgt_pkg::ADDR_DC_LOW) |=> dc_r[7:0] == $past(reg_wdata))
    else $error("Down counter low byte did not take the write.");

  a_reload_latch: assert property (@(posedge clk) disable iff (!resetn)
    prm_wr |=> (lat_a_r == $past(gra_r)) && (lat_b_r == $past(grb_r)))
    else $error("Guard reloads not copied on mode write.");

  a_reload_hold: assert property (@(posedge clk) disable iff (!resetn)
    !prm_wr |=> $stable(lat_a_r) && $stable(lat_b_r))
    else $error("Guard reload copy changed without a mode write.");

  a_ts_timeout: assert property (@(posedge clk) disable iff (!resetn)
    ts_expire |=> sts_r[sgt_pkg::IRQ_TS_WAIT_BIT] && rx_fifo_block && st_r == SGT_ATR_DONE)
    else $error("Initial character timeout did not flag and block.");

  a_tx_guard_hold: assert property (@(posedge clk) disable iff (!resetn)
    (en_r && !prm_wr && !gclr && !wr_at(sgt_pkg::ADDR_ICTL) && st_r == SGT_PROTO &&
     rx_char_done && lat_b_r != 8'h00)
    |=> !tx_allow ##1 !tx_allow)
    else $error("Transmit not held after a received character.");

  a_tx_free_off: assert property (@(posedge clk) disable iff (!resetn)
    !en_r |=> tx_allow)
    else $error("Transmit held while guard timer disabled.");

  a_clear_enable: assert property (@(posedge clk) disable iff (!resetn)
    gclr |=> !en_r ##1 st_r == SGT_IDLE)
    else $error("Guard clear did not stop the timer.");

  a_reset_pulse: assert property (@(posedge clk) disable iff (!resetn)
    st_r == SGT_RST_PULSE |-> !card_reset_line)
    else $error("Card reset line high during the reset pulse.");

  a_irq_level: assert property (@(posedge clk) disable iff (!resetn)
    ##1 irq == |(sts_r & msk_r))
    else $error("Interrupt output disagrees with masked status.");

endmodule

// ### tb/sgt_card_model.sv
// Card model for the guard timer unit: answers reset release and sends characters.
// Assumes the receiver that sits between card and timer reports whole characters.
`timescale 1ns/100ps
module sgt_card_model (
  // Clock and card pins
  input  wire logic clk,
  input  wire logic card_reset_line,
  // Scenario control
  input  wire logic answer_en,
  input  wire logic slow,
  input  wire logic send_char,
  // Receiver events
  output logic      rx_start_bit,
  output logic      rx_char_done
);
  // ----------------------------------------------------------------------
  // Character timing
  // ----------------------------------------------------------------------
  logic rst_q;
  int   cnt;

  initial begin
    rst_q        = 1'b0;
    cnt          = 0;
    rx_start_bit = 1'b0;
    rx_char_done = 1'b0;
  end

  // A slow card waits far longer before its start bit, to stress the answer window.
  always @(posedge clk) begin
    rst_q        <= card_reset_line;
    rx_start_bit <= (cnt == 11);
    rx_char_done <= (cnt == 1);
    if ((card_reset_line && !rst_q && answer_en) || send_char) begin
      cnt <= slow ? 40 : 12;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// ### tb/test_sgt_timers.sv
// Self-checking bench for the guard timer unit with a card model on the far side.
// Assumes the package, the design and the card model are compiled before it.
`timescale 1ns/100ps
module test_sgt_timers;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic        clk, resetn, reg_wr, reg_rd, etu_tick, rx_start_bit, rx_char_done;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, extra_guard, d;
  logic [15:0] char_wait_reload;
  logic        tx_allow, rx_fifo_block, card_reset_line, irq, answer_en, slow, send_char;
  int          fail_count, tests_run, ra, rb;
  int          mdl[int];

  sgt_timers u_sgt_timers (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .etu_tick(etu_tick), .rx_start_bit(rx_start_bit), .rx_char_done(rx_char_done),
    .tx_allow(tx_allow), .rx_fifo_block(rx_fifo_block), .extra_guard(extra_guard),
    .char_wait_reload(char_wait_reload), .card_reset_line(card_reset_line), .irq(irq));

  sgt_card_model u_sgt_card_model (.clk(clk), .card_reset_line(card_reset_line),
    .answer_en(answer_en), .slow(slow), .send_char(send_char),
    .rx_start_bit(rx_start_bit), .rx_char_done(rx_char_done));

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    if (a >= 8'h16 && a <= 8'h1D) mdl[a] = v;
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic st;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // Ticks are spaced four cycles apart so each one settles before the next.
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      etu_tick <= 1'b1;
      @(posedge clk);
      etu_tick <= 1'b0;
      repeat (2) @(posedge clk);
    end
    #1;
  endtask

  task automatic char_in;
    @(posedge clk);
    send_char <= 1'b1;
    @(posedge clk);
    send_char <= 1'b0;
    repeat (14) @(posedge clk);
    #1;
  endtask

  // ----------------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    complete_run;
  end

  initial begin
    {reg_wr, reg_rd, etu_tick, answer_en, slow, send_char} = '0;
    {reg_addr, reg_wdata} = '0;
    resetn     = 1'b0;
    fail_count = 0;
    tests_run  = 0;
    void'($urandom(32'h08f9));
    ra = 2 + $urandom % 3;
    rb = 2 + $urandom % 3;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    st;
    chk("tx allow", 1, tx_allow);
    chk("card reset", 0, card_reset_line);
    for (int i = 0; i < 8; i++) begin
      rd(8'h16 + i[7:0]);
      chk("reset value", (i < 2) ? 16'h00FF : 16'h0000, d);
    end
    for (int i = 0; i < 8; i++) wr(8'h16 + i[7:0], 8'($urandom));
    for (int i = 0; i < 8; i++) begin
      rd(8'h16 + i[7:0]);
      chk("readback", 16'(mdl[8'h16 + i]), d);
    end
    rd(8'h30);
    chk("unmapped", 0, d);
    chk("char wait", 16'(mdl[8'h19] * 256 + mdl[8'h18]), char_wait_reload);
    // Down counter event drives the interrupt path: raised, masked, cleared.
    wr(8'h16, 8'h02);
    wr(8'h17, 8'h00);
    wr(8'h22, 8'h00);
    tick(1);
    rd(8'h21);
    chk("count status", 0, d & 8'h02);
    tick(1);
    rd(8'h21);
    chk("count status", 2, d & 8'h02);
    chk("irq masked", 0, irq);
    wr(8'h22, 8'h02);
    st;
    chk("irq raised", 1, irq);
    wr(8'h21, 8'h02);
    st;
    chk("irq cleared", 0, irq);
    // Reload latching and protocol modes.
    wr(8'h1C, 8'(ra));
    wr(8'h1D, 8'(rb));
    wr(8'h1E, 8'h00);
    st;
    chk("extra guard", 16'(ra), extra_guard);
    wr(8'h1C, 8'(ra) ^ 8'hFF);
    st;
    chk("extra guard held", 16'(ra), extra_guard);
    wr(8'h1E, 8'h02);
    st;
    chk("extra guard new", 16'(8'(ra) ^ 8'hFF), extra_guard);
    wr(8'h20, 8'h01);
    char_in;
    chk("tx held", 0, tx_allow);
    tick(rb - 1);
    chk("tx held", 0, tx_allow);
    tick(1);
    chk("tx free", 1, tx_allow);
    wr(8'h20, 8'h00);
    char_in;
    chk("tx no delay", 1, tx_allow);
    // Spacing watch: two etu allowed, the third etu after the start bit flags.
    wr(8'h1B, 8'h02);
    wr(8'h1A, 8'h00);
    wr(8'h21, 8'h04);
    char_in;
    tick(2);
    rd(8'h21);
    chk("spacing quiet", 0, d & 8'h04);
    tick(1);
    rd(8'h21);
    chk("spacing late", 4, d & 8'h04);
    // Answer-to-reset: a slow card answers in time, then a silent card times out.
    wr(8'h1C, 8'(ra));
    wr(8'h1E, 8'h01);
    wr(8'h22, 8'h01);
    answer_en <= 1'b1;
    slow      <= 1'b1;
    wr(8'h20, 8'h01);
    st;
    chk("atr guard", 0, extra_guard);
    chk("reset pulse", 0, card_reset_line);
    tick(rb - 1);
    chk("reset pulse", 0, card_reset_line);
    tick(1);
    chk("reset release", 1, card_reset_line);
    tick(ra - 1);
    repeat (30) @(posedge clk);
    tick(ra + 1);
    chk("answered", 0, rx_fifo_block);
    answer_en <= 1'b0;
    slow      <= 1'b0;
    wr(8'h1E, 8'h01);
    st;
    chk("reset pulse", 0, card_reset_line);
    tick(rb - 1);
    chk("reset pulse", 0, card_reset_line);
    tick(1);
    chk("reset release", 1, card_reset_line);
    tick(ra - 1);
    chk("wait open", 0, rx_fifo_block);
    tick(1);
    chk("fifo blocked", 1, rx_fifo_block);
    chk("wait irq", 1, irq);
    wr(8'h1F, 8'h80);
    st;
    chk("irq withdrawn", 0, irq);
    rd(8'h20);
    chk("enable off", 0, d & 8'h01);
    rd(8'h1F);
    chk("clear reads zero", 0, d);
    chk("block stands", 1, rx_fifo_block);
    wr(8'h1E, 8'h00);
    st;
    chk("block lifted", 0, rx_fifo_block);
    complete_run;
  end
endmodule
